/* File: wcr_pkg.sv */
package wcr_pkg;

   // register geometry
   localparam int unsigned REG_W    = 5;
   localparam int unsigned ADDR_W   = 3;
   localparam int unsigned NUM_REGS = 5;
   localparam int unsigned MULT_W   = 6;

   // register offsets on the command port
   localparam logic [ADDR_W-1:0] OFS_MODE_AND_PLL_A  = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_INPUT_MULT_PLL_B = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_FIRST_OUT_MULT  = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_SECOND_OUT_MULT = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_DRIVER_CONTROL  = 3'h4;

   // value after reset, common to every register
   localparam logic [REG_W-1:0] REG_RESET = 5'h00;

   // field positions
   localparam int unsigned LOOP_EN_BIT    = 0;
   localparam int unsigned FIELD4_LSB     = 1;
   localparam int unsigned FIELD4_MSB     = 4;
   localparam int unsigned FRAME_EN_BIT   = 4;
   localparam int unsigned OUT1_EN_BIT    = 3;
   localparam int unsigned OUT2_EN_BIT    = 2;
   localparam int unsigned LOCK_SEL_MSB   = 1;
   localparam int unsigned LOCK_SEL_LSB   = 0;

   // configuration mode codes that need special handling
   localparam logic [3:0] CODE_REV_56   = 4'h3;
   localparam logic [3:0] CODE_REV_64   = 4'h7;
   localparam logic [3:0] CODE_E1_TO_T1 = 4'h8;
   localparam logic [3:0] CODE_FRAC_LO  = 4'h9;
   localparam logic [3:0] CODE_FRAC_HI  = 4'hc;
   localparam logic [3:0] CODE_HS_REV   = 4'hd;
   localparam logic [3:0] CODE_RSVD_LO  = 4'he;

   // multiples of unity and the legal high-speed multiples
   localparam logic [MULT_W-1:0] MULT_ONE   = 6'h01;
   localparam logic [MULT_W-1:0] MULT_TWO   = 6'h02;
   localparam logic [MULT_W-1:0] MULT_FOUR  = 6'h04;
   localparam logic [MULT_W-1:0] MULT_EIGHT = 6'h08;

   // lock indicator source selection
   typedef enum logic [1:0] {
      LOCK_BOTH   = 2'h0,
      LOCK_B_ONLY = 2'h1,
      LOCK_A_ONLY = 2'h2,
      LOCK_LOW    = 2'h3
   } wcr_lock_sel_t;

   // operating mode classes
   typedef enum logic [2:0] {
      CLS_FORWARD   = 3'h0,
      CLS_REVERSE   = 3'h1,
      CLS_E1_TO_T1  = 3'h2,
      CLS_FRACTION  = 3'h3,
      CLS_HS_REV    = 3'h4,
      CLS_RESERVED  = 3'h5,
      CLS_SLV_FWD   = 3'h6,
      CLS_SLV_REV   = 3'h7
   } wcr_class_t;

   // kind of reference expected on the reference clock input
   typedef enum logic [2:0] {
      REF_T1_MULT = 3'h0,
      REF_E1_MULT = 3'h1,
      REF_56K     = 3'h2,
      REF_64K     = 3'h3,
      REF_8K      = 3'h4,
      REF_NONE    = 3'h5
   } wcr_ref_t;

   // kind of clock produced on an output
   typedef enum logic [2:0] {
      OUT_K56     = 3'h0,
      OUT_K64     = 3'h1,
      OUT_T1      = 3'h2,
      OUT_E1      = 3'h3,
      OUT_E1_MULT = 3'h4,
      OUT_NONE    = 3'h5
   } wcr_out_t;

   // decoded operating mode handed to the loop logic
   typedef struct packed {
      logic       master;
      wcr_class_t cls;
      wcr_ref_t   ref_kind;
      wcr_out_t   out1;
      wcr_out_t   out2;
   } wcr_mode_t;

   // multiples handed to the loop dividers
   typedef struct packed {
      logic [MULT_W-1:0] ref_mult;
      logic [MULT_W-1:0] out1_mult;
      logic [MULT_W-1:0] out2_mult;
   } wcr_mults_t;

endpackage : wcr_pkg

/* File: wcr_mode_decode.sv */
module wcr_mode_decode (
   // strap and mode code
   input  wire logic            master_i,
   input  wire logic [3:0]      code_i,
   // decoded mode
   output wcr_pkg::wcr_mode_t   mode_o
);

   wcr_pkg::wcr_class_t cls;
   wcr_pkg::wcr_ref_t   ref_kind;
   wcr_pkg::wcr_out_t   out1;
   wcr_pkg::wcr_out_t   out2;

   // output kinds are shared by both tables except for code 1000
   always_comb begin
      out1 = wcr_pkg::OUT_NONE;
      out2 = wcr_pkg::OUT_NONE;
      case (code_i)
         4'h0, 4'h4: begin
            out1 = wcr_pkg::OUT_K56;
            out2 = wcr_pkg::OUT_K56;
         end
         4'h1, 4'h5: begin
            out1 = wcr_pkg::OUT_K56;
            out2 = wcr_pkg::OUT_K64;
         end
         4'h2, 4'h6: begin
            out1 = wcr_pkg::OUT_K64;
            out2 = wcr_pkg::OUT_K64;
         end
         4'h3, 4'h7, 4'h9: begin
            out1 = wcr_pkg::OUT_T1;
            out2 = wcr_pkg::OUT_E1;
         end
         4'h8: begin
            out1 = master_i ? wcr_pkg::OUT_T1 : wcr_pkg::OUT_K56;
            out2 = master_i ? wcr_pkg::OUT_T1 : wcr_pkg::OUT_K64;
         end
         4'ha: begin
            out1 = wcr_pkg::OUT_T1;
            out2 = wcr_pkg::OUT_T1;
         end
         4'hb: begin
            out1 = wcr_pkg::OUT_E1;
            out2 = wcr_pkg::OUT_T1;
         end
         4'hc: begin
            out1 = wcr_pkg::OUT_E1;
            out2 = wcr_pkg::OUT_E1;
         end
         4'hd: begin
            out1 = wcr_pkg::OUT_E1_MULT;
            out2 = wcr_pkg::OUT_E1_MULT;
         end
         default: begin
            out1 = wcr_pkg::OUT_NONE;
            out2 = wcr_pkg::OUT_NONE;
         end
      endcase
   end

   // mode class and reference kind, master and slave tables
   always_comb begin
      cls      = wcr_pkg::CLS_RESERVED;
      ref_kind = wcr_pkg::REF_NONE;
      if (code_i >= wcr_pkg::CODE_RSVD_LO) begin
         cls      = wcr_pkg::CLS_RESERVED;
         ref_kind = wcr_pkg::REF_NONE;
      end else if (code_i == wcr_pkg::CODE_HS_REV) begin
         cls      = wcr_pkg::CLS_HS_REV;
         ref_kind = wcr_pkg::REF_64K;
      end else if (!master_i) begin
         cls      = (code_i == wcr_pkg::CODE_REV_56 || code_i >= wcr_pkg::CODE_REV_64) ?
                    wcr_pkg::CLS_SLV_REV : wcr_pkg::CLS_SLV_FWD;
         ref_kind = wcr_pkg::REF_8K;
      end else begin
         case (code_i)
            4'h0, 4'h1, 4'h2: begin
               cls      = wcr_pkg::CLS_FORWARD;
               ref_kind = wcr_pkg::REF_T1_MULT;
            end
            4'h4, 4'h5, 4'h6: begin
               cls      = wcr_pkg::CLS_FORWARD;
               ref_kind = wcr_pkg::REF_E1_MULT;
            end
            wcr_pkg::CODE_REV_56: begin
               cls      = wcr_pkg::CLS_REVERSE;
               ref_kind = wcr_pkg::REF_56K;
            end
            wcr_pkg::CODE_REV_64: begin
               cls      = wcr_pkg::CLS_REVERSE;
               ref_kind = wcr_pkg::REF_64K;
            end
            wcr_pkg::CODE_E1_TO_T1: begin
               cls      = wcr_pkg::CLS_E1_TO_T1;
               ref_kind = wcr_pkg::REF_E1_MULT;
            end
            4'h9, 4'ha: begin
               cls      = wcr_pkg::CLS_FRACTION;
               ref_kind = wcr_pkg::REF_56K;
            end
            4'hb, 4'hc: begin
               cls      = wcr_pkg::CLS_FRACTION;
               ref_kind = wcr_pkg::REF_64K;
            end
            default: begin
               cls      = wcr_pkg::CLS_RESERVED;
               ref_kind = wcr_pkg::REF_NONE;
            end
         endcase
      end
   end

   assign mode_o = '{master: master_i, cls: cls, ref_kind: ref_kind, out1: out1, out2: out2};

endmodule : wcr_mode_decode

/* File: wcr_config_regs.sv */
// Summary of operation
// - mode code decodes by master or slave table per strap; 1110 and 1111 reserved.
// - master codes map to forward, reverse, E1-to-T1, fractional and high-speed modes.
// - slave codes 0000-1100 lock to 8kHz; 1101 stays high-speed reverse at 64kHz.
// - bit 0 of the first register enables the first loop.
// - bit 0 of the second register enables the second loop.
// - bits 4-1 of the second register hold input multiple N, up to 16.
// - forward mode, third register sets first output multiplier K up to 32.
// - fractional reverse mode, third register sets input multiple P up to 32.
// - high-speed mode, third register is first output M; only 1, 2, 4, 8 allowed.
// - forward mode, fourth register sets second output multiplier K up to 32.
// - high-speed mode, fourth register is second output M; only 1, 2, 4, 8 allowed.
// - high-speed mode takes 64kHz and drives both outputs at M times 2.048MHz.
// - bit 4 of the fifth register enables the frame pulse driver.
// - bit 3 of the fifth register enables the first clock output driver.
// - bit 2 of the fifth register enables the second clock output driver.
// - bits 1-0 of fifth register pick lock pin source: both, B, A, low.
module wcr_config_regs (
   // clock and reset
   input  wire logic                          CORE_CLK_I,
   input  wire logic                          RST_N_I,
   // command port from the serial engine
   input  wire logic                          REG_WR_I,
   input  wire logic                          REG_RD_I,
   input  wire logic [wcr_pkg::ADDR_W-1:0]    REG_ADDR_I,
   input  wire logic [wcr_pkg::REG_W-1:0]     REG_WDATA_I,
   output logic      [wcr_pkg::REG_W-1:0]     REG_RDATA_O,
   output logic                               REG_RVALID_O,
   // strap and loop status pins
   input  wire logic                          MASTER_STRAP_I,
   input  wire logic                          FIRST_LOOP_LOCK_I,
   input  wire logic                          SECOND_LOOP_LOCK_I,
   // loop control
   output logic                               FIRST_LOOP_ENABLE_O,
   output logic                               SECOND_LOOP_ENABLE_O,
   output wcr_pkg::wcr_mode_t                 MODE_O,
   output wcr_pkg::wcr_mults_t                MULTS_O,
   output logic                               CONFIG_ERROR_O,
   // output drivers and lock pin
   output logic                               FRAME_PULSE_DRIVER_ENABLE_O,
   output logic                               FIRST_OUTPUT_DRIVER_ENABLE_O,
   output logic                               SECOND_OUTPUT_DRIVER_ENABLE_O,
   output logic                               LOCK_INDICATOR_PIN_O
);

   localparam int unsigned SYNC_W = 3;
   localparam logic [wcr_pkg::MULT_W-1:0] MULT_ONE_W = wcr_pkg::MULT_ONE;

   // register storage
   logic [wcr_pkg::REG_W-1:0] regs [wcr_pkg::NUM_REGS];

   // synchroniser stages
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] pin_meta;
   logic [SYNC_W-1:0] pin_sync;

   // named fields
   logic [3:0]                mode_code;
   logic                      first_loop_enable;
   logic                      second_loop_enable;
   logic [3:0]                input_multiple_field;
   logic [4:0]                first_output_multiplier_field;
   logic [4:0]                second_output_multiplier_field;
   logic                      frame_pulse_driver_enable;
   logic                      first_output_driver_enable;
   logic                      second_output_driver_enable;
   wcr_pkg::wcr_lock_sel_t    lock_output_select;

   // derived values
   logic                      master_mode;
   logic                      first_lock;
   logic                      second_lock;
   wcr_pkg::wcr_mode_t        next_mode;
   wcr_pkg::wcr_mults_t       next_mults;
   logic [wcr_pkg::MULT_W-1:0] n_value;
   logic [wcr_pkg::MULT_W-1:0] k1_value;
   logic [wcr_pkg::MULT_W-1:0] k2_value;
   logic [wcr_pkg::MULT_W-1:0] m1_value;
   logic [wcr_pkg::MULT_W-1:0] m2_value;
   logic                      m1_legal;
   logic                      m2_legal;
   logic                      is_forward;
   logic                      is_hs;
   logic                      next_error;
   logic                      combined_lock;
   logic                      next_lock;
   logic                      addr_mapped;
   logic [wcr_pkg::REG_W-1:0] next_rdata;

   // pins from outside the clock domain pass two flops before use
   assign pin_raw = {SECOND_LOOP_LOCK_I, FIRST_LOOP_LOCK_I, MASTER_STRAP_I};

   generate
      for (genvar s = 0; s < SYNC_W; s++) begin : g_sync
         always_ff @(posedge CORE_CLK_I) begin
            if (!RST_N_I) begin
               pin_meta[s] <= 1'b0;
               pin_sync[s] <= 1'b0;
            end else begin
               pin_meta[s] <= pin_raw[s];
               pin_sync[s] <= pin_meta[s];
            end
         end
      end
   endgenerate

   assign master_mode = pin_sync[0];
   assign first_lock  = pin_sync[1];
   assign second_lock = pin_sync[2];

   // register file: one write strobe per entry, all cleared by reset
   generate
      for (genvar r = 0; r < wcr_pkg::NUM_REGS; r++) begin : g_reg
         logic hit;
         assign hit = REG_WR_I && (REG_ADDR_I == (wcr_pkg::ADDR_W)'(r));
         always_ff @(posedge CORE_CLK_I) begin
            if (!RST_N_I) begin
               regs[r] <= wcr_pkg::REG_RESET;
            end else if (hit) begin
               regs[r] <= REG_WDATA_I;
            end
         end
      end
   endgenerate

   // field extraction
   assign mode_code          = regs[wcr_pkg::OFS_MODE_AND_PLL_A]
                               [wcr_pkg::FIELD4_MSB:wcr_pkg::FIELD4_LSB];
   assign first_loop_enable  = regs[wcr_pkg::OFS_MODE_AND_PLL_A][wcr_pkg::LOOP_EN_BIT];
   assign second_loop_enable = regs[wcr_pkg::OFS_INPUT_MULT_PLL_B]
                               [wcr_pkg::LOOP_EN_BIT];
   assign input_multiple_field = regs[wcr_pkg::OFS_INPUT_MULT_PLL_B]
                                 [wcr_pkg::FIELD4_MSB:wcr_pkg::FIELD4_LSB];
   assign first_output_multiplier_field  = regs[wcr_pkg::OFS_FIRST_OUT_MULT];
   assign second_output_multiplier_field = regs[wcr_pkg::OFS_SECOND_OUT_MULT];
   assign frame_pulse_driver_enable   = regs[wcr_pkg::OFS_DRIVER_CONTROL]
                                        [wcr_pkg::FRAME_EN_BIT];
   assign first_output_driver_enable  = regs[wcr_pkg::OFS_DRIVER_CONTROL]
                                        [wcr_pkg::OUT1_EN_BIT];
   assign second_output_driver_enable = regs[wcr_pkg::OFS_DRIVER_CONTROL]
                                        [wcr_pkg::OUT2_EN_BIT];
   assign lock_output_select = wcr_pkg::wcr_lock_sel_t'(regs[wcr_pkg::OFS_DRIVER_CONTROL]
                               [wcr_pkg::LOCK_SEL_MSB:wcr_pkg::LOCK_SEL_LSB]);

   // mode table lookup
   wcr_mode_decode u_decode (
      .master_i (master_mode),
      .code_i   (mode_code),
      .mode_o   (next_mode)
   );

   // fields hold value minus one, so the true multiple is field plus one
   assign n_value  = {2'b00, input_multiple_field} + MULT_ONE_W;
   assign k1_value = {1'b0, first_output_multiplier_field} + MULT_ONE_W;
   assign k2_value = {1'b0, second_output_multiplier_field} + MULT_ONE_W;

   // the high-speed multiple is written as the plain value, not minus one
   assign m1_value = {1'b0, first_output_multiplier_field};
   assign m2_value = {1'b0, second_output_multiplier_field};

   assign m1_legal = (m1_value == wcr_pkg::MULT_ONE) || (m1_value == wcr_pkg::MULT_TWO) ||
                     (m1_value == wcr_pkg::MULT_FOUR) || (m1_value == wcr_pkg::MULT_EIGHT);
   assign m2_legal = (m2_value == wcr_pkg::MULT_ONE) || (m2_value == wcr_pkg::MULT_TWO) ||
                     (m2_value == wcr_pkg::MULT_FOUR) || (m2_value == wcr_pkg::MULT_EIGHT);

   assign is_forward = (next_mode.cls == wcr_pkg::CLS_FORWARD) ||
                       (next_mode.cls == wcr_pkg::CLS_SLV_FWD);
   assign is_hs      = (next_mode.cls == wcr_pkg::CLS_HS_REV);

   // multiples handed to the dividers; unused ones sit at unity
   always_comb begin
      next_mults = '{ref_mult: wcr_pkg::MULT_ONE, out1_mult: wcr_pkg::MULT_ONE,
                     out2_mult: wcr_pkg::MULT_ONE};
      case (next_mode.cls)
         wcr_pkg::CLS_FORWARD: begin
            next_mults.ref_mult  = n_value;
            next_mults.out1_mult = k1_value;
            next_mults.out2_mult = k2_value;
         end
         wcr_pkg::CLS_SLV_FWD: begin
            next_mults.out1_mult = k1_value;
            next_mults.out2_mult = k2_value;
         end
         wcr_pkg::CLS_E1_TO_T1: begin
            next_mults.ref_mult = n_value;
         end
         wcr_pkg::CLS_FRACTION: begin
            next_mults.ref_mult = k1_value;
         end
         wcr_pkg::CLS_HS_REV: begin
            next_mults.out1_mult = m1_value;
            next_mults.out2_mult = m2_value;
         end
         default: begin
            next_mults = '{ref_mult: wcr_pkg::MULT_ONE, out1_mult: wcr_pkg::MULT_ONE,
                           out2_mult: wcr_pkg::MULT_ONE};
         end
      endcase
   end

   // a reserved code or an illegal high-speed multiple is flagged, never fixed up
   assign next_error = (next_mode.cls == wcr_pkg::CLS_RESERVED) ||
                       (is_hs && !(m1_legal && m2_legal));

   // combined lock follows only the loops that are enabled
   always_comb begin
      combined_lock = 1'b0;
      case ({first_loop_enable, second_loop_enable})
         2'b11:   combined_lock = first_lock && second_lock;
         2'b10:   combined_lock = first_lock;
         2'b01:   combined_lock = second_lock;
         default: combined_lock = 1'b0;
      endcase
   end

   // lock pin source; forced low overrides every loop state
   always_comb begin
      next_lock = 1'b0;
      case (lock_output_select)
         wcr_pkg::LOCK_BOTH:   next_lock = combined_lock;
         wcr_pkg::LOCK_B_ONLY: next_lock = second_lock;
         wcr_pkg::LOCK_A_ONLY: next_lock = first_lock;
         wcr_pkg::LOCK_LOW:    next_lock = 1'b0;
         default:              next_lock = 1'b0;
      endcase
   end

   // read mux; offsets above the table, reserved ones included, read zero
   assign addr_mapped = (REG_ADDR_I < (wcr_pkg::ADDR_W)'(wcr_pkg::NUM_REGS));
   assign next_rdata  = addr_mapped ? regs[REG_ADDR_I] : wcr_pkg::REG_RESET;

   // read answer: data and valid one edge after the request
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         REG_RDATA_O  <= wcr_pkg::REG_RESET;
         REG_RVALID_O <= 1'b0;
      end else begin
         REG_RDATA_O  <= REG_RD_I ? next_rdata : REG_RDATA_O;
         REG_RVALID_O <= REG_RD_I;
      end
   end

   // loop control outputs, registered so the pins never glitch on decode
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         FIRST_LOOP_ENABLE_O  <= 1'b0;
         SECOND_LOOP_ENABLE_O <= 1'b0;
         MODE_O               <= '0;
         MULTS_O              <= '0;
         CONFIG_ERROR_O       <= 1'b0;
      end else begin
         FIRST_LOOP_ENABLE_O  <= first_loop_enable;
         SECOND_LOOP_ENABLE_O <= second_loop_enable;
         MODE_O               <= next_mode;
         MULTS_O              <= next_mults;
         CONFIG_ERROR_O       <= next_error;
      end
   end

   // driver enables and lock pin
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         FRAME_PULSE_DRIVER_ENABLE_O   <= 1'b0;
         FIRST_OUTPUT_DRIVER_ENABLE_O  <= 1'b0;
         SECOND_OUTPUT_DRIVER_ENABLE_O <= 1'b0;
         LOCK_INDICATOR_PIN_O          <= 1'b0;
      end else begin
         FRAME_PULSE_DRIVER_ENABLE_O   <= frame_pulse_driver_enable;
         FIRST_OUTPUT_DRIVER_ENABLE_O  <= first_output_driver_enable;
         SECOND_OUTPUT_DRIVER_ENABLE_O <= second_output_driver_enable;
         LOCK_INDICATOR_PIN_O          <= next_lock;
      end
   end

endmodule : wcr_config_regs

/* File: wcr_config_regs_props.sv */
module wcr_config_regs_props (
   // watched ports of the register bank
   input wire logic                       CORE_CLK_I, RST_N_I, REG_WR_I, REG_RD_I,
   input wire logic [wcr_pkg::ADDR_W-1:0] REG_ADDR_I,
   input wire logic [wcr_pkg::REG_W-1:0]  REG_WDATA_I, REG_RDATA_O,
   input wire logic                       REG_RVALID_O, MASTER_STRAP_I, FIRST_LOOP_LOCK_I,
   input wire logic                       SECOND_LOOP_LOCK_I, FIRST_LOOP_ENABLE_O,
   input wire logic                       SECOND_LOOP_ENABLE_O,
   input wire wcr_pkg::wcr_mode_t         MODE_O,
   input wire wcr_pkg::wcr_mults_t        MULTS_O,
   input wire logic                       CONFIG_ERROR_O, FRAME_PULSE_DRIVER_ENABLE_O,
   input wire logic                       FIRST_OUTPUT_DRIVER_ENABLE_O,
   input wire logic                       SECOND_OUTPUT_DRIVER_ENABLE_O, LOCK_INDICATOR_PIN_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);

   // high-speed multiples outside 1, 2, 4, 8 must raise the error level
   wire bad1 = !(MULTS_O.out1_mult inside {6'h01, 6'h02, 6'h04, 6'h08});
   wire bad2 = !(MULTS_O.out2_mult inside {6'h01, 6'h02, 6'h04, 6'h08});
   wire hs   = MODE_O.cls == wcr_pkg::CLS_HS_REV;

   // a write to one offset followed by a cycle without one, so the output is settled
   sequence s_wr(int a);
      REG_WR_I && REG_ADDR_I == a ##1 !(REG_WR_I && REG_ADDR_I == a);
   endsequence
   sequence s_strap;
      ($stable(MASTER_STRAP_I) && RST_N_I) [*4];
   endsequence

   a_loop_a_follow : assert property (s_wr(0) |=> FIRST_LOOP_ENABLE_O == $past(REG_WDATA_I[0], 2))
      else $error("first loop enable differs from its register bit");
   a_loop_b_follow : assert property (s_wr(1) |=> SECOND_LOOP_ENABLE_O == $past(REG_WDATA_I[0], 2))
      else $error("second loop enable differs from its register bit");
   a_drivers_follow : assert property (s_wr(4) |=> {FRAME_PULSE_DRIVER_ENABLE_O,
      FIRST_OUTPUT_DRIVER_ENABLE_O, SECOND_OUTPUT_DRIVER_ENABLE_O} == $past(REG_WDATA_I[4:2], 2))
      else $error("driver enables differ from their register bits");
   a_lock_forced_low : assert property (REG_WR_I && REG_ADDR_I == 4 && REG_WDATA_I[1:0] == 2'h3
      ##1 !(REG_WR_I && REG_ADDR_I == 4) |=> !LOCK_INDICATOR_PIN_O)
      else $error("lock pin not low with forced-low select");
   a_reset_clears : assert property (disable iff (1'b0) !RST_N_I |=> !FIRST_LOOP_ENABLE_O
      && !SECOND_LOOP_ENABLE_O && !FIRST_OUTPUT_DRIVER_ENABLE_O && MULTS_O == '0 && !REG_RVALID_O)
      else $error("outputs not cleared by reset");
   a_error_cause : assert property (CONFIG_ERROR_O == (MODE_O.cls == wcr_pkg::CLS_RESERVED
      || (hs && (bad1 || bad2))))
      else $error("config error level does not match mode and multiples");
   a_hs_ref_rate : assert property (hs |-> MODE_O.ref_kind == wcr_pkg::REF_64K)
      else $error("high-speed mode without 64k reference");
   a_slave_ref_rate : assert property (MODE_O.cls inside {wcr_pkg::CLS_SLV_FWD, wcr_pkg::CLS_SLV_REV}
      |-> MODE_O.ref_kind == wcr_pkg::REF_8K && !MODE_O.master)
      else $error("slave mode without 8k reference");
   a_strap_table : assert property (s_strap |-> MODE_O.master == MASTER_STRAP_I)
      else $error("table choice does not follow the strap");
endmodule : wcr_config_regs_props

bind wcr_config_regs wcr_config_regs_props i_props (.*);

/* File: wcr_host_model.sv */
module wcr_host_model (
   // command port towards the register bank
   input  wire logic                       clk_i,
   output logic                            wr_o,
   output logic                            rd_o,
   output logic [wcr_pkg::ADDR_W-1:0]      addr_o,
   output logic [wcr_pkg::REG_W-1:0]       wdata_o,
   input  wire logic [wcr_pkg::REG_W-1:0]  rdata_i,
   input  wire logic                       rvalid_i
);
   initial begin
      {wr_o, rd_o, addr_o, wdata_o} = '0;
   end
   // idle bus shows the inverse of the last value so nothing stale can match
   task automatic put(input logic [2:0] a, input logic [4:0] d);
      @(negedge clk_i);
      {wr_o, addr_o, wdata_o} = {1'b1, a, d};
      @(negedge clk_i);
      {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
   endtask : put
   task automatic get(input logic [2:0] a, output logic [4:0] d, output logic v);
      @(negedge clk_i);
      {rd_o, addr_o} = {1'b1, a};
      @(negedge clk_i);
      {rd_o, addr_o} = {1'b0, ~a};
      v = rvalid_i;
      d = rdata_i;
   endtask : get
   // software codes N and K as the value minus one
   task automatic prog_n(input int n, input logic en);
      put(3'h1, {4'(n - 1), en});
   endtask : prog_n
   task automatic prog_k(input logic [2:0] a, input int k);
      put(a, 5'(k - 1));
   endtask : prog_k
endmodule : wcr_host_model

/* File: test_dual_pll_clock_config_regs.sv */
module test_dual_pll_clock_config_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, strap = 0, lk1 = 0, lk2 = 0;
   logic wr, rd, rv, err, en1, en2, fen, oen1, oen2, lock;
   logic [2:0] addr;
   logic [4:0] wd, rdat;
   wcr_pkg::wcr_mode_t  mode;
   wcr_pkg::wcr_mults_t mults;
   int n_mismatch = 0, samples_checked = 0;
   always #2 clk = ~clk;

   wcr_config_regs i_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .REG_RVALID_O(rv),
      .MASTER_STRAP_I(strap), .FIRST_LOOP_LOCK_I(lk1), .SECOND_LOOP_LOCK_I(lk2),
      .FIRST_LOOP_ENABLE_O(en1), .SECOND_LOOP_ENABLE_O(en2), .MODE_O(mode), .MULTS_O(mults),
      .CONFIG_ERROR_O(err), .FRAME_PULSE_DRIVER_ENABLE_O(fen), .FIRST_OUTPUT_DRIVER_ENABLE_O(oen1),
      .SECOND_OUTPUT_DRIVER_ENABLE_O(oen2), .LOCK_INDICATOR_PIN_O(lock));
   wcr_host_model i_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd),
      .rdata_i(rdat), .rvalid_i(rv));

   task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   // derived outputs land one edge after the register, pins need three edges
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask : settle
   task automatic rdck(input logic [2:0] a, input logic [4:0] exp);
      logic [4:0] d;
      logic v;
      i_host.get(a, d, v);
      chk(v, 1'b1, "read valid");
      chk(d, exp, "read data");
   endtask : rdck
   function automatic wcr_pkg::wcr_class_t exp_cls(input logic m, input logic [3:0] c);
      if (c > 4'hd) return wcr_pkg::CLS_RESERVED;
      if (c == 4'hd) return wcr_pkg::CLS_HS_REV;
      if (!m) return (c == 4'h3 || c > 4'h6) ? wcr_pkg::CLS_SLV_REV : wcr_pkg::CLS_SLV_FWD;
      if (c == 4'h3 || c == 4'h7) return wcr_pkg::CLS_REVERSE;
      if (c == 4'h8) return wcr_pkg::CLS_E1_TO_T1;
      return (c > 4'h8) ? wcr_pkg::CLS_FRACTION : wcr_pkg::CLS_FORWARD;
   endfunction : exp_cls

   task automatic t_regs;
      logic [4:0] v [5] = '{5'h15, 5'h0b, 5'h1f, 5'h01, 5'h1c};
      for (int a = 0; a < 8; a++) rdck(3'(a), 5'h00);
      chk({en1, en2, fen, oen1, oen2, lock, err}, 7'h00, "idle outputs");
      for (int a = 0; a < 5; a++) i_host.put(3'(a), v[a]);
      i_host.put(3'h5, 5'h1f);
      for (int a = 0; a < 5; a++) rdck(3'(a), v[a]);
      rdck(3'h5, 5'h00);
      chk({en1, en2, fen, oen1, oen2}, 5'h1f, "enables set");
      $display("t_regs done");
   endtask : t_regs
   task automatic t_modes(input logic m);
      strap = m;
      i_host.put(3'h2, 5'h01);
      i_host.put(3'h3, 5'h02);
      settle(4);
      for (int c = 0; c < 16; c++) begin
         i_host.put(3'h0, {c[3:0], m});
         settle(2);
         chk(mode.cls, exp_cls(m, c[3:0]), "mode class");
         chk({mode.master, en1, err}, {m, m, c > 13}, "strap enable error");
      end
      $display("t_modes done");
   endtask : t_modes
   task automatic t_mults;
      i_host.put(3'h0, 5'h01);
      i_host.prog_n(16, 1'b1);
      i_host.prog_k(3'h2, 32);
      i_host.prog_k(3'h3, 1);
      settle(2);
      chk(mults, {6'h10, 6'h20, 6'h01}, "forward multiples");
      i_host.put(3'h0, 5'h13);
      settle(2);
      chk({mults.ref_mult, mode.ref_kind, mode.out1, mode.out2}, {6'h20, wcr_pkg::REF_56K,
         wcr_pkg::OUT_T1, wcr_pkg::OUT_E1}, "fraction multiple and kinds");
      i_host.put(3'h0, 5'h1b);
      i_host.put(3'h2, 5'h08);
      i_host.put(3'h3, 5'h04);
      settle(2);
      chk({mults.out1_mult, mults.out2_mult, err}, {6'h08, 6'h04, 1'b0}, "high speed");
      chk({mode.ref_kind, mode.out1, mode.out2}, {wcr_pkg::REF_64K, wcr_pkg::OUT_E1_MULT,
         wcr_pkg::OUT_E1_MULT}, "high speed reference and kinds");
      i_host.put(3'h3, 5'h03);
      settle(2);
      chk(err, 1'b1, "illegal multiple");
      $display("t_mults done");
   endtask : t_mults
   task automatic t_lock;
      i_host.put(3'h1, 5'h01);
      for (int s = 0; s < 4; s++) for (int p = 0; p < 4; p++) begin
         i_host.put(3'h4, {3'h5, s[1:0]});
         {lk1, lk2} = p[1:0];
         settle(4);
         chk(lock, s == 0 ? lk1 & lk2 : s == 1 ? lk2 : s == 2 ? lk1 : 1'b0, "lock pin");
      end
      chk({fen, oen1, oen2}, 3'h5, "driver enables");
      i_host.put(3'h1, 5'h00);
      {lk1, lk2} = 2'h2;
      i_host.put(3'h4, 5'h00);
      settle(4);
      chk(lock, 1'b1, "single loop lock");
      $display("t_lock done");
   endtask : t_lock

   task automatic test_done;
      $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done

   // watchdog: a hung run still reaches the verdict
   initial begin
      repeat (50000) @(posedge clk);
      n_mismatch++;
      $display("unexpected at %0t: run timed out", $time);
      test_done;
   end
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1;
      t_regs;
      t_modes(1'b0);
      t_modes(1'b1);
      t_mults;
      t_lock;
      test_done;
   end
endmodule : test_dual_pll_clock_config_regs
